// File: cmb_console.sv
/*
  Console mailbox, microroutine launch, interrupt freeze and internal-bus
  maintenance access. Assumes host microcode, the microstack and the
  internal bus run on clk, so their signals need no synchroniser.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cmb_console
  import cmb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DW-1:0] reg_rdata,
  input wire logic host_mbx_rd,
  input wire logic host_mbx_wr,
  input wire logic [2*DW-1:0] host_mbx_wdata,
  output logic [2*DW-1:0] host_mbx_rdata,
  output logic host_tx_irq,
  output logic host_rx_irq,
  input wire logic console_loop,
  output logic pop_jump,
  input wire logic host_clk_run,
  input wire logic [1:0] clock_phase_point,
  input wire logic single_cycle_advance,
  output cmb_ib_req_s ib_req,
  input wire logic [2*DW-1:0] ib_rdata,
  input wire logic ib_ack
);
  logic [DW-1:0] to_lo_reg;
  logic [DW-1:0] to_hi_reg;
  logic [DW-1:0] fm_lo_reg;
  logic [DW-1:0] fm_hi_reg;
  logic tx_ready_reg;
  logic rx_done_reg;
  logic console_io_reg;
  logic freeze_reg;
  logic pop_jump_reg;
  logic [IBAW-1:0] ib_addr_reg;
  logic ib_write_reg;
  logic ib_cycle_reg;
  logic ib_hold_reg;
  logic ib_done_reg;
  logic ib_wr_stb_reg;
  logic ib_rd_stb_reg;
  logic tx_irq_reg;
  logic rx_irq_reg;
  logic [DW-1:0] rdata_reg;
  cmb_ib_state_e ib_state_reg;
  logic wr_to_lo, wr_to_hi, wr_flags, wr_mcr, wr_ibcs;
  logic strobe_ok, run_start, stop_write, live_en;
  logic [DW-1:0] flags_word;
  logic [DW-1:0] mcr_word;
  logic [DW-1:0] ibcs_word;

  // Write decode for the console port.
  assign wr_to_lo = reg_we && (reg_addr == OFS_TO_LO);
  assign wr_to_hi = reg_we && (reg_addr == OFS_TO_HI);
  assign wr_flags = reg_we && (reg_addr == OFS_FLAGS);
  assign wr_mcr = reg_we && (reg_addr == OFS_MCR);
  assign wr_ibcs = reg_we && (reg_addr == OFS_IBCS);

  // The live read enable is only meaningful outside phase zero.
  assign strobe_ok = (clock_phase_point != PHASE_ZERO);
  assign run_start = host_clk_run && ib_cycle_reg && (ib_state_reg == CMB_IB_IDLE);
  assign stop_write = !host_clk_run && ib_hold_reg && ib_write_reg
    && (clock_phase_point == PHASE_ZERO) && single_cycle_advance;
  // Combinational so that a phase change is seen at once.
  assign live_en = !host_clk_run && ib_hold_reg && !ib_write_reg && strobe_ok;

  // To-CPU mailbox, written only by console software.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      to_lo_reg <= ZERO16;
      to_hi_reg <= ZERO16;
    end else begin
      if (wr_to_lo) begin
        to_lo_reg <= reg_wdata;
      end
      if (wr_to_hi) begin
        to_hi_reg <= reg_wdata;
      end
    end
  end

  // From-CPU mailbox: host load or completed running read.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fm_lo_reg <= ZERO16;
      fm_hi_reg <= ZERO16;
    end else if (ib_state_reg == CMB_IB_BUSY && ib_ack && !ib_write_reg) begin
      fm_lo_reg <= ib_rdata[DW-1:0];
      fm_hi_reg <= ib_rdata[2*DW-1:DW];
    end else if (host_mbx_wr) begin
      fm_lo_reg <= host_mbx_wdata[DW-1:0];
      fm_hi_reg <= host_mbx_wdata[2*DW-1:DW];
    end
  end

  // Interlock flags; a software set wins over a same-cycle host clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ready_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      if (wr_flags && reg_wdata[FLG_TX_READY]) begin
        tx_ready_reg <= 1'b1;
      end else if (wr_flags) begin
        tx_ready_reg <= 1'b0;
      end else if (host_mbx_wr) begin
        tx_ready_reg <= 1'b0;
      end
      if (wr_flags && reg_wdata[FLG_RX_DONE]) begin
        rx_done_reg <= 1'b1;
      end else if (wr_flags) begin
        rx_done_reg <= 1'b0;
      end else if (host_mbx_rd) begin
        rx_done_reg <= 1'b0;
      end
    end
  end

  // Maintenance control: mode, freeze and the pop-and-jump pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      console_io_reg <= 1'b0;
      freeze_reg <= 1'b0;
      pop_jump_reg <= 1'b0;
    end else begin
      pop_jump_reg <= wr_mcr && reg_wdata[MCR_POP_JUMP];
      if (wr_mcr) begin
        console_io_reg <= reg_wdata[MCR_CONSOLE_IO];
        freeze_reg <= reg_wdata[MCR_FREEZE];
      end
    end
  end

  // Host interrupt requests follow the flags in program I/O mode only.
  // While frozen they keep their value so software may reuse the flags.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
    end else if (!freeze_reg) begin
      tx_irq_reg <= tx_ready_reg && !console_io_reg;
      rx_irq_reg <= rx_done_reg && !console_io_reg;
    end
  end

  // Internal-bus control/status register and hold-access handling.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ib_addr_reg <= ZERO8;
      ib_write_reg <= 1'b0;
      ib_cycle_reg <= 1'b0;
      ib_hold_reg <= 1'b0;
      ib_done_reg <= 1'b0;
    end else begin
      if (wr_ibcs) begin
        ib_addr_reg <= reg_wdata[IBAW-1:0];
        ib_write_reg <= reg_wdata[IBCS_WRITE];
        ib_hold_reg <= reg_wdata[IBCS_HOLD];
      end else if (stop_write) begin
        ib_hold_reg <= 1'b0;
      end
      if (wr_ibcs && reg_wdata[IBCS_CYCLE]) begin
        ib_cycle_reg <= 1'b1;
        ib_done_reg <= 1'b0;
      end else if (ib_state_reg == CMB_IB_BUSY && ib_ack) begin
        ib_cycle_reg <= 1'b0;
        ib_done_reg <= 1'b1;
      end
    end
  end

  // Running-clock cycle: one strobe, then wait for the bus to answer.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ib_state_reg <= CMB_IB_IDLE;
    end else begin
      case (ib_state_reg)
        CMB_IB_IDLE: begin
          if (run_start) begin
            ib_state_reg <= CMB_IB_BUSY;
          end
        end
        CMB_IB_BUSY: begin
          if (ib_ack) begin
            ib_state_reg <= CMB_IB_IDLE;
          end
        end
        default: begin
          ib_state_reg <= CMB_IB_IDLE;
        end
      endcase
    end
  end

  // Bus strobes are registered one-cycle pulses.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ib_wr_stb_reg <= 1'b0;
      ib_rd_stb_reg <= 1'b0;
    end else begin
      ib_wr_stb_reg <= (run_start && ib_write_reg) || stop_write;
      ib_rd_stb_reg <= run_start && !ib_write_reg;
    end
  end

  // Readback words are built field by field, so reserved bits read as zero
  // and no field can slide if a position constant moves.
  always_comb begin
    flags_word = ZERO16;
    flags_word[FLG_TX_READY] = tx_ready_reg;
    flags_word[FLG_RX_DONE] = rx_done_reg;
  end

  // Maintenance control readback; the console-loop flag is read-only.
  always_comb begin
    mcr_word = ZERO16;
    mcr_word[MCR_CONSOLE_IO] = console_io_reg;
    mcr_word[MCR_FREEZE] = freeze_reg;
    mcr_word[MCR_CONSOLE_LOOP] = console_loop;
  end

  // Internal-bus control/status readback, done bit included.
  always_comb begin
    ibcs_word = ZERO16;
    ibcs_word[IBAW-1:0] = ib_addr_reg;
    ibcs_word[IBCS_WRITE] = ib_write_reg;
    ibcs_word[IBCS_CYCLE] = ib_cycle_reg;
    ibcs_word[IBCS_HOLD] = ib_hold_reg;
    ibcs_word[IBCS_DONE] = ib_done_reg;
  end

  // Read data stands in the cycle after the read strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= ZERO16;
    end else if (!reg_re) begin
      rdata_reg <= ZERO16;
    end else if (reg_addr == OFS_TO_LO) begin
      rdata_reg <= to_lo_reg;
    end else if (reg_addr == OFS_TO_HI) begin
      rdata_reg <= to_hi_reg;
    end else if (reg_addr == OFS_FM_LO) begin
      rdata_reg <= fm_lo_reg;
    end else if (reg_addr == OFS_FM_HI) begin
      rdata_reg <= fm_hi_reg;
    end else if (reg_addr == OFS_FLAGS) begin
      rdata_reg <= flags_word;
    end else if (reg_addr == OFS_MCR) begin
      rdata_reg <= mcr_word;
    end else if (reg_addr == OFS_IBCS) begin
      rdata_reg <= ibcs_word;
    end else if (reg_addr == OFS_LIVE_LO) begin
      rdata_reg <= live_en ? ib_rdata[DW-1:0] : ZERO16;
    end else if (reg_addr == OFS_LIVE_HI) begin
      rdata_reg <= live_en ? ib_rdata[2*DW-1:DW] : ZERO16;
    end else begin
      rdata_reg <= ZERO16;
    end
  end

  // Output drive. Write data always comes from the to-CPU mailbox.
  assign reg_rdata = rdata_reg;
  assign host_mbx_rdata = {to_hi_reg, to_lo_reg};
  assign host_tx_irq = tx_irq_reg;
  assign host_rx_irq = rx_irq_reg;
  assign pop_jump = pop_jump_reg;
  assign ib_req.addr = ib_addr_reg;
  assign ib_req.wdata = {to_hi_reg, to_lo_reg};
  assign ib_req.wr_stb = ib_wr_stb_reg;
  assign ib_req.rd_stb = ib_rd_stb_reg;
  assign ib_req.rd_en = live_en;

  // Checks that sit beside the logic they guard.
  AST_NO_IRQ_CONSOLE: assert property (@(posedge clk) disable iff (sys_rst)
    console_io_reg && !freeze_reg && $past(console_io_reg) && !$past(freeze_reg)
    |-> !host_tx_irq && !host_rx_irq)
    else $error("Host interrupt raised in console mode.");
  AST_POP_JUMP: assert property (@(posedge clk) disable iff (sys_rst)
    wr_mcr && reg_wdata[MCR_POP_JUMP] |=> pop_jump ##1 !pop_jump)
    else $error("Pop-and-jump pulse wrong.");
  AST_FREEZE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    freeze_reg |=> $stable(host_tx_irq) && $stable(host_rx_irq))
    else $error("Interrupt logic moved while frozen.");
  AST_RUN_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    run_start && ib_write_reg |=> ib_req.wr_stb && ib_req.wdata == {to_hi_reg, to_lo_reg})
    else $error("Maintenance write not issued.");
  AST_RUN_READ: assert property (@(posedge clk) disable iff (sys_rst)
    ib_state_reg == CMB_IB_BUSY && ib_ack && !ib_write_reg && !wr_ibcs |=>
    {fm_hi_reg, fm_lo_reg} == $past(ib_rdata) && !ib_cycle_reg)
    else $error("Read data not captured.");
  AST_PHASE_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    clock_phase_point == PHASE_ZERO |-> !ib_req.rd_en)
    else $error("Live strobe in phase zero.");
  AST_LIVE_DATA: assert property (@(posedge clk) disable iff (sys_rst)
    reg_re && reg_addr == OFS_LIVE_LO && live_en |=> reg_rdata == $past(ib_rdata[DW-1:0]))
    else $error("Live data wrong.");
  AST_STOP_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    stop_write && !wr_ibcs |=> ib_req.wr_stb && !ib_hold_reg)
    else $error("Stopped write failed.");
  AST_RX_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    host_mbx_rd && !wr_flags |=> !rx_done_reg)
    else $error("Receive-done not cleared.");
  AST_TX_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    host_mbx_wr && !wr_flags |=> !tx_ready_reg)
    else $error("Transmit-ready not cleared.");
  AST_LIVE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    host_clk_run || !ib_hold_reg || ib_write_reg |-> !ib_req.rd_en)
    else $error("Live read enabled outside a stopped read.");
  AST_RUN_START: assert property (@(posedge clk) disable iff (sys_rst)
    run_start && !ib_write_reg |=> ib_req.rd_stb && !ib_req.wr_stb)
    else $error("Maintenance read not issued.");
endmodule
`default_nettype wire

// File: cmb_pkg.sv
/*
  Constants, register map and carrier types for the console mailbox block.
  Assumes one clock domain shared by console software, host microcode
  and the internal-bus logic of the host.
*/
package cmb_pkg;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 16;
  localparam int unsigned IBAW = 8;
  // Register indices on the console port.
  localparam logic [AW-1:0] OFS_TO_LO = 4'h0;
  localparam logic [AW-1:0] OFS_TO_HI = 4'h1;
  localparam logic [AW-1:0] OFS_FM_LO = 4'h2;
  localparam logic [AW-1:0] OFS_FM_HI = 4'h3;
  localparam logic [AW-1:0] OFS_FLAGS = 4'h4;
  localparam logic [AW-1:0] OFS_MCR = 4'h5;
  localparam logic [AW-1:0] OFS_IBCS = 4'h6;
  localparam logic [AW-1:0] OFS_LIVE_LO = 4'h7;
  localparam logic [AW-1:0] OFS_LIVE_HI = 4'h8;
  // Flag register fields.
  localparam int unsigned FLG_TX_READY = 0;
  localparam int unsigned FLG_RX_DONE = 1;
  // Maintenance control register fields.
  localparam int unsigned MCR_CONSOLE_IO = 0;
  localparam int unsigned MCR_FREEZE = 8;
  localparam int unsigned MCR_POP_JUMP = 9;
  localparam int unsigned MCR_CONSOLE_LOOP = 10;
  // Internal-bus control/status fields.
  localparam int unsigned IBCS_WRITE = 8;
  localparam int unsigned IBCS_CYCLE = 9;
  localparam int unsigned IBCS_HOLD = 10;
  localparam int unsigned IBCS_DONE = 11;
  // Reset values and the phase-zero point.
  localparam logic [DW-1:0] ZERO16 = 16'h0000;
  localparam logic [IBAW-1:0] ZERO8 = 8'h00;
  localparam logic [1:0] PHASE_ZERO = 2'h0;

  typedef enum logic [0:0] {
    CMB_IB_IDLE = 1'b0,
    CMB_IB_BUSY = 1'b1
  } cmb_ib_state_e;

  // Request carried onto the host internal bus.
  typedef struct packed {
    logic [IBAW-1:0] addr;
    logic [2*DW-1:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic rd_en;
  } cmb_ib_req_s;
endpackage

// File: cmb_ib_model.sv
/*
  Host internal-bus model: a register file of 256 words behind the bus request.
  Assumes the request struct and clk of the console block, one domain.
  A second write port stands for host microcode storing words of its own.
*/
`timescale 1ns/100ps
`default_nettype none
module cmb_ib_model
  import cmb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire cmb_ib_req_s ib_req,
  input wire logic clk_run,
  input wire logic slow,
  input wire logic mc_we,
  input wire logic [IBAW-1:0] mc_addr,
  input wire logic [2*DW-1:0] mc_wdata,
  output logic [2*DW-1:0] ib_rdata,
  output var logic ib_ack
);
  logic [2*DW-1:0] mem [0:255];
  logic [3:0] wait_cnt;
  logic busy_reg;
  logic rd_cyc_reg;
  logic [2*DW-1:0] last_reg;

  // A write strobe lands in the addressed word, clock running or stepped.
  always_ff @(posedge clk) begin
    if (ib_req.wr_stb) begin
      mem[ib_req.addr] <= ib_req.wdata;
    end else if (mc_we) begin
      mem[mc_addr] <= mc_wdata;
    end
  end

  // Running cycles end with an ack, promptly or after a stall.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      rd_cyc_reg <= 1'b0;
      wait_cnt <= 4'h0;
      ib_ack <= 1'b0;
    end else begin
      ib_ack <= 1'b0;
      if ((ib_req.wr_stb || ib_req.rd_stb) && clk_run) begin
        busy_reg <= 1'b1;
        rd_cyc_reg <= ib_req.rd_stb;
        wait_cnt <= slow ? 4'h6 : 4'h0;
      end else if (busy_reg) begin
        if (wait_cnt == 4'h0) begin
          ib_ack <= 1'b1;
          busy_reg <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end

  // An undriven bus shows the inverse of its last value, so stale data never matches.
  assign ib_rdata = (ib_req.rd_en || (ib_ack && rd_cyc_reg)) ? mem[ib_req.addr] : ~last_reg;
  always_ff @(posedge clk) begin
    last_reg <= ib_rdata;
  end
endmodule
`default_nettype wire

// File: test_cmb_console.sv
/*
  Self-checking bench for the console mailbox block and its bus model.
  Assumes the register index map and field positions of cmb_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module test_cmb_console
  import cmb_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic host_mbx_rd = 1'b0;
  logic host_mbx_wr = 1'b0;
  logic [2*DW-1:0] host_mbx_wdata = '0;
  logic [2*DW-1:0] host_mbx_rdata;
  logic host_tx_irq;
  logic host_rx_irq;
  logic console_loop = 1'b0;
  logic pop_jump;
  logic host_clk_run = 1'b1;
  logic [1:0] clock_phase_point = 2'h0;
  logic single_cycle_advance = 1'b0;
  cmb_ib_req_s ib_req;
  logic [2*DW-1:0] ib_rdata;
  logic ib_ack;
  logic slow = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int pj_cnt = 0;
  logic [DW-1:0] d;
  logic mc_we = 1'b0;
  logic [IBAW-1:0] ustack_top = 8'h00;
  logic [IBAW-1:0] jump_target = 8'h00;
  // Halt-reason word location and code are arbitrary test values.
  localparam logic [IBAW-1:0] HALT_ADDR = 8'h0d;
  localparam logic [2*DW-1:0] HALT_CODE = 32'h00000006;

  always #2 clk = ~clk;

  cmb_console cmb_console_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .host_mbx_rd(host_mbx_rd), .host_mbx_wr(host_mbx_wr), .host_mbx_wdata(host_mbx_wdata),
    .host_mbx_rdata(host_mbx_rdata), .host_tx_irq(host_tx_irq), .host_rx_irq(host_rx_irq),
    .console_loop(console_loop), .pop_jump(pop_jump), .host_clk_run(host_clk_run),
    .clock_phase_point(clock_phase_point), .single_cycle_advance(single_cycle_advance),
    .ib_req(ib_req), .ib_rdata(ib_rdata), .ib_ack(ib_ack));
  cmb_ib_model cmb_ib_model_i (.clk(clk), .sys_rst(sys_rst), .ib_req(ib_req),
    .clk_run(host_clk_run), .slow(slow), .mc_we(mc_we), .mc_addr(HALT_ADDR),
    .mc_wdata(HALT_CODE), .ib_rdata(ib_rdata), .ib_ack(ib_ack));

  // Pulses are counted so a stuck or doubled launch shows up.
  // The microstack top is taken as the jump target when the pulse comes.
  always @(posedge clk) begin
    if (pop_jump === 1'b1) begin
      pj_cnt++;
      jump_target <= ustack_top;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Starts a running-clock cycle and waits a bounded time for the ack.
  task automatic ib_run(input logic [7:0] a, input logic w, input logic late);
    int i;
    if (late) wr(OFS_IBCS, {7'h00, w, a});
    wr(OFS_IBCS, {6'h00, 1'b1, w, a});
    for (i = 0; i < 40 && ib_ack !== 1'b1; i++) @(posedge clk);
    if (ib_ack !== 1'b1) chk(1'b0, 1'b1);
    settle();
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The whole sequence runs well under 2000 cycles.
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wr(OFS_FLAGS, 16'h0003);
    settle();
    chk({host_tx_irq, host_rx_irq}, 2'b11);
    wr(OFS_TO_LO, 16'h1234);
    wr(OFS_TO_HI, 16'h5678);
    rdchk(OFS_FLAGS, 16'h0003);
    @(posedge clk) host_mbx_rd <= 1'b1;
    @(posedge clk) host_mbx_rd <= 1'b0;
    settle();
    chk(host_mbx_rdata, 32'h56781234);
    rdchk(OFS_FLAGS, 16'h0001);
    @(posedge clk) begin
      host_mbx_wr <= 1'b1;
      host_mbx_wdata <= 32'hcafef00d;
    end
    @(posedge clk) host_mbx_wr <= 1'b0;
    rdchk(OFS_FLAGS, 16'h0000);
    rdchk(OFS_FM_LO, 16'hf00d);
    rdchk(OFS_FM_HI, 16'hcafe);
    wr(OFS_FLAGS, 16'h0003);
    rdchk(OFS_TO_LO, 16'h1234);
    rdchk(OFS_FLAGS, 16'h0003);
    wr(OFS_MCR, 16'h0100);
    wr(OFS_FLAGS, 16'h0000);
    settle();
    chk({host_tx_irq, host_rx_irq}, 2'b11);
    wr(OFS_MCR, 16'h0000);
    settle();
    chk({host_tx_irq, host_rx_irq}, 2'b00);
    wr(OFS_MCR, 16'h0001);
    wr(OFS_FLAGS, 16'h0003);
    settle();
    chk({host_tx_irq, host_rx_irq}, 2'b00);
    @(posedge clk) console_loop <= 1'b1;
    mc_we <= 1'b1;
    @(posedge clk) mc_we <= 1'b0;
    rdchk(OFS_MCR, 16'h0401);
    ib_run(HALT_ADDR, 1'b0, 1'b0);
    rdchk(OFS_FM_LO, HALT_CODE[DW-1:0]);
    rdchk(OFS_FM_HI, HALT_CODE[2*DW-1:DW]);
    @(posedge clk) ustack_top <= 8'h3c;
    wr(OFS_MCR, 16'h0201);
    @(posedge clk) console_loop <= 1'b0;
    settle();
    chk(pj_cnt, 1);
    chk(jump_target, 8'h3c);
    rdchk(OFS_MCR, 16'h0001);
    @(posedge clk) console_loop <= 1'b1;
    rdchk(OFS_MCR, 16'h0401);
    wr(OFS_TO_LO, 16'h2222);
    wr(OFS_TO_HI, 16'h1111);
    ib_run(8'h21, 1'b1, 1'b1);
    chk(cmb_ib_model_i.mem[8'h21], 32'h11112222);
    wr(OFS_TO_LO, 16'h4444);
    wr(OFS_TO_HI, 16'h3333);
    ib_run(8'h42, 1'b1, 1'b0);
    chk(cmb_ib_model_i.mem[8'h42], 32'h33334444);
    ib_run(8'h21, 1'b0, 1'b0);
    rdchk(OFS_FM_LO, 16'h2222);
    rdchk(OFS_FM_HI, 16'h1111);
    @(posedge clk) slow <= 1'b1;
    ib_run(8'h42, 1'b0, 1'b0);
    rdchk(OFS_FM_HI, 16'h3333);
    rd(OFS_IBCS, d);
    chk(d[IBCS_DONE], 1'b1);
    @(posedge clk) host_clk_run <= 1'b0;
    clock_phase_point <= 2'h2;
    wr(OFS_IBCS, 16'h0421);
    rdchk(OFS_LIVE_LO, 16'h2222);
    rdchk(OFS_LIVE_HI, 16'h1111);
    wr(OFS_IBCS, 16'h0442);
    rdchk(OFS_LIVE_HI, 16'h3333);
    @(posedge clk) clock_phase_point <= 2'h0;
    settle();
    chk(ib_req.rd_en, 1'b0);
    wr(OFS_TO_LO, 16'h5555);
    wr(OFS_TO_HI, 16'h6666);
    wr(OFS_IBCS, 16'h0530);
    @(posedge clk) single_cycle_advance <= 1'b1;
    @(posedge clk) single_cycle_advance <= 1'b0;
    settle();
    chk(cmb_ib_model_i.mem[8'h30], 32'h66665555);
    rd(OFS_IBCS, d);
    chk(d[IBCS_HOLD], 1'b0);
    wr(OFS_IBCS, 16'h0000);
    @(posedge clk) host_clk_run <= 1'b1;
    wr(OFS_FLAGS, 16'h0001);
    wr(OFS_TO_LO, 16'h1234);
    wr(OFS_TO_HI, 16'h5678);
    wr(OFS_FLAGS, 16'h0003);
    @(posedge clk) ustack_top <= 8'h5a;
    wr(OFS_MCR, 16'h0200);
    settle();
    chk(pj_cnt, 2);
    chk(jump_target, 8'h5a);
    chk(host_mbx_rdata, 32'h56781234);
    chk({host_tx_irq, host_rx_irq}, 2'b11);
    // An unmapped index must read back as zero.
    rdchk(4'hf, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
